// file: logic/caf_filter.sv
// Notes on behaviour
// - Four mask registers, indices zero to three
// - Sixteen filter registers holding pattern and type
// - Standard id bits 31:21, extended 17:0
// - Bits 20 and 18 read zero, ignore writes
// - Mask standard bit one compares, zero ignores
// - Mask extended bit one compares, zero ignores
// - Enabled standard bits must equal filter bits
// - Enabled extended bits must equal filter bits
// - Type match set: frame type must agree
// - Type match clear: any frame type accepted
// - Filter type bit selects extended or standard
// - Masks writable only in configuration mode
// - Filter writable only while filter disabled
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "caf_consts.svh"
module caf_filter import caf_pkg::*; #(
	parameter int NUM_FILT = 16,
	parameter int NUM_MASK = 4
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic rx_valid,
	input wire logic [10:0] rx_std_id,
	input wire logic [17:0] rx_ext_id,
	input wire logic rx_is_ext,
	output logic match_valid,
	output logic match_hit,
	output logic [3:0] match_index,
	output logic [2:0] operating_mode_field
);
	// Module state in one struct; filter words are held in the memory
	typedef struct packed {
		// Mask words, unimplemented bits held at zero
		logic [NUM_MASK-1:0][31:0] mask;
		// One enable per filter; a set bit locks that filter
		logic [NUM_FILT-1:0] enable;
		// Which mask each filter compares under
		logic [NUM_FILT-1:0][1:0] mask_sel;
		// Operating mode; configuration value opens the masks
		logic [2:0] mode;
		// Sequencer phase
		caf_phase_t phase;
		// Memory index issued this cycle; one wider to mark the end
		logic [4:0] scan_idx;
		// Captured standard identifier
		logic [10:0] id_std;
		// Captured extended identifier
		logic [17:0] id_ext;
		// Captured frame type
		logic id_is_ext;
		// Some filter has hit in this scan
		logic hit;
		// Lowest filter that hit
		logic [3:0] hit_idx;
		// One-cycle result strobe
		logic res_valid;
		// Result hit, held until the next result
		logic res_hit;
		// Result index, held until the next result
		logic [3:0] res_idx;
		// Every filter that hit in the latest scan
		logic [NUM_FILT-1:0] last_hits;
		// Read answer due this cycle
		logic rd_pend;
		// Read answer comes from the filter memory
		logic rd_from_mem;
		// Read answer for register-held words
		logic [31:0] rd_word;
	} caf_state_t;

	caf_state_t st_ff;
	caf_state_t nxt_st;

	// Filter words live in the memory; scan and bus reads share its port
	logic filt_wr;
	logic [3:0] filt_wr_idx;
	logic [3:0] filt_rd_idx;
	logic [31:0] filt_rdata;
	logic scan_cmp;
	logic filt_hit;
	logic [1:0] cmp_sel;
	logic [4:0] cmp_idx;

	// Address class decode, used for both write and read paths
	// Shifts rather than part-selects, since a literal cannot be sliced
	function automatic logic is_mask_addr(input logic [7:0] a);
		return ((a >> 4) == (`CAF_MASK_BASE >> 4)) && (a[1:0] == 2'h0);
	endfunction
	// Filter words fill the whole second quarter, just below the control words
	function automatic logic is_filt_addr(input logic [7:0] a);
		return ((a >> 6) == (`CAF_FILT_BASE >> 6)) && (a[1:0] == 2'h0);
	endfunction
	// Mask select is a 2-bit field per filter, sixteen words from the base
	function automatic logic is_sel_addr(input logic [7:0] a);
		return (a >= `CAF_SEL_BASE) && (a <= `CAF_SEL_LAST) && (a[1:0] == 2'h0);
	endfunction
	// Filter number behind a mask-select address
	function automatic logic [3:0] sel_idx(input logic [7:0] a);
		logic [7:0] off;
		off = a - `CAF_SEL_BASE;
		return off[5:2];
	endfunction

	// Compare one filter word under one mask word
	function automatic logic word_match(
		input logic [31:0] filt,
		input logic [31:0] msk,
		input logic [10:0] sid,
		input logic [17:0] eid,
		input logic is_ext
	);
		logic sid_ok;
		logic eid_ok;
		logic type_ok;
		sid_ok = (((filt[`CAF_SID_HI:`CAF_SID_LO] ^ sid) & msk[`CAF_SID_HI:`CAF_SID_LO])
			== 11'h000);
		// A standard frame has no extended bits, so they only count for extended frames
		eid_ok = !is_ext || (((filt[`CAF_EID_HI:`CAF_EID_LO] ^ eid)
			& msk[`CAF_EID_HI:`CAF_EID_LO]) == 18'h00000);
		// Type bit of the filter only matters when the mask asks for it
		type_ok = !msk[`CAF_TYPE_BIT] || (filt[`CAF_TYPE_BIT] == is_ext);
		return sid_ok && eid_ok && type_ok;
	endfunction

	// Filter memory: sixteen words, registered read
	// Keeping filters out of flops trades one cycle of latency per word for area
	caf_word_mem #(
		.DEPTH(NUM_FILT),
		.AW(4)
	) u_filt_mem (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.wr_en(filt_wr),
		.wr_addr(filt_wr_idx),
		.wr_data(reg_wdata & `CAF_WORD_MASK),
		.rd_addr(filt_rd_idx),
		.rd_data(filt_rdata)
	);

	// Filter writes only land while that filter is disabled
	assign filt_wr_idx = reg_addr[5:2];
	assign filt_wr = reg_wr && is_filt_addr(reg_addr) && !st_ff.enable[reg_addr[5:2]];

	// Bus read has priority on the memory port; scan holds its index then
	assign filt_rd_idx = (reg_rd && is_filt_addr(reg_addr)) ? reg_addr[5:2] : st_ff.scan_idx[3:0];

	// Word from memory belongs to the index issued one cycle earlier
	assign cmp_idx = st_ff.scan_idx - 5'h01;
	assign cmp_sel = st_ff.mask_sel[cmp_idx[3:0]];
	assign scan_cmp = (st_ff.phase == CAF_SCAN) && (st_ff.scan_idx != 5'h00) && !st_ff.rd_from_mem;
	assign filt_hit = scan_cmp && st_ff.enable[cmp_idx[3:0]]
		&& word_match(filt_rdata, st_ff.mask[cmp_sel], st_ff.id_std, st_ff.id_ext, st_ff.id_is_ext);

	// Next-state logic: register writes, scan sequencing, read mux
	always_comb begin
		nxt_st = st_ff;
		nxt_st.res_valid = 1'b0;
		nxt_st.rd_pend = 1'b0;
		nxt_st.rd_from_mem = 1'b0;

		// Register writes
		if (reg_wr) begin
			// Masks only move in configuration mode; other writes fall through
			if (is_mask_addr(reg_addr) && st_ff.mode == `CAF_MODE_CONFIG) begin
				nxt_st.mask[reg_addr[3:2]] = reg_wdata & `CAF_WORD_MASK;
			end else if (reg_addr == `CAF_ENABLE_ADDR) begin
				// Enables are never locked, so software can always disable
				nxt_st.enable = reg_wdata[NUM_FILT-1:0];
			end else if (reg_addr == `CAF_MODE_ADDR) begin
				// Mode word, low three bits only
				nxt_st.mode = reg_wdata[2:0];
			end else if (is_sel_addr(reg_addr)) begin
				// Selects follow the filter write lock as part of the filter setup
				if (!st_ff.enable[sel_idx(reg_addr)]) begin
					nxt_st.mask_sel[sel_idx(reg_addr)] = reg_wdata[1:0];
				end
			end else begin
				// Unmapped or locked write: ignored
				nxt_st.mode = st_ff.mode;
			end
		end

		// Read data capture; memory reads resolve one cycle later
		if (reg_rd) begin
			nxt_st.rd_pend = 1'b1;
			nxt_st.rd_word = 32'h0000_0000;
			if (is_mask_addr(reg_addr)) begin
				// Mask words are held in flops
				nxt_st.rd_word = st_ff.mask[reg_addr[3:2]];
			end else if (is_filt_addr(reg_addr)) begin
				// Filter words arrive from the memory's output register
				nxt_st.rd_from_mem = 1'b1;
			end else if (reg_addr == `CAF_ENABLE_ADDR) begin
				nxt_st.rd_word = {{(32-NUM_FILT){1'b0}}, st_ff.enable};
			end else if (reg_addr == `CAF_MODE_ADDR) begin
				nxt_st.rd_word = {29'h0000_0000, st_ff.mode};
			end else if (reg_addr == `CAF_STATUS_ADDR) begin
				// Hit map may be read mid-scan; it then shows a partial map
				nxt_st.rd_word = {st_ff.last_hits, 11'h000, st_ff.res_hit, st_ff.res_idx};
			end else if (is_sel_addr(reg_addr)) begin
				// Select of one filter, upper bits zero
				nxt_st.rd_word = {30'h0000_0000, st_ff.mask_sel[sel_idx(reg_addr)]};
			end else begin
				// Unmapped address reads zero
				nxt_st.rd_word = 32'h0000_0000;
			end
		end

		// Matching sequencer
		case (st_ff.phase)
			CAF_IDLE: begin
				// Identifiers are only taken here; offers during a scan are lost
				if (rx_valid) begin
					nxt_st.id_std = rx_std_id;
					nxt_st.id_ext = rx_ext_id;
					nxt_st.id_is_ext = rx_is_ext;
					nxt_st.hit = 1'b0;
					nxt_st.hit_idx = 4'h0;
					nxt_st.last_hits = '0;
					nxt_st.scan_idx = 5'h00;
					nxt_st.phase = CAF_SCAN;
				end
			end
			CAF_SCAN: begin
				// A bus read steals the memory port; the scan stalls that cycle
				if (!(reg_rd && is_filt_addr(reg_addr))) begin
					if (filt_hit) begin
						nxt_st.last_hits[cmp_idx[3:0]] = 1'b1;
						// Lowest numbered hit wins
						if (!st_ff.hit) begin
							nxt_st.hit = 1'b1;
							nxt_st.hit_idx = cmp_idx[3:0];
						end
					end
					// Index past the last filter means its word was just compared
					if (st_ff.scan_idx == 5'(NUM_FILT)) begin
						nxt_st.phase = CAF_DONE;
					end else begin
						// Issue the next filter word
						nxt_st.scan_idx = st_ff.scan_idx + 5'h01;
					end
				end else if (filt_hit) begin
					// Compare still valid for the word already fetched
					nxt_st.last_hits[cmp_idx[3:0]] = 1'b1;
					if (!st_ff.hit) begin
						nxt_st.hit = 1'b1;
						nxt_st.hit_idx = cmp_idx[3:0];
					end
					nxt_st.scan_idx = st_ff.scan_idx;
				end else begin
					// No hit on the fetched word; just hold the index
					nxt_st.scan_idx = st_ff.scan_idx;
				end
			end
			CAF_DONE: begin
				// Publish the result for one strobe cycle
				nxt_st.res_valid = 1'b1;
				nxt_st.res_hit = st_ff.hit;
				nxt_st.res_idx = st_ff.hit_idx;
				nxt_st.phase = CAF_IDLE;
			end
			default: begin
				// Unreachable phase recovers to idle
				nxt_st.phase = CAF_IDLE;
			end
		endcase
	end

	// State register
	// Reset opens the masks so software can set them up straight away
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			// All state cleared, mode set to configuration
			st_ff <= '0;
			st_ff.mode <= `CAF_MODE_RST;
			st_ff.phase <= CAF_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs
	// Read data is zero outside the answer cycle, so stray samples read clean
	assign reg_rdata = !st_ff.rd_pend ? 32'h0000_0000 :
		(st_ff.rd_from_mem ? filt_rdata : st_ff.rd_word);
	// Result strobe and held result, all straight from flops
	assign match_valid = st_ff.res_valid;
	assign match_hit = st_ff.res_hit;
	assign match_index = st_ff.res_idx;
	// Mode is shown to the rest of the controller
	assign operating_mode_field = st_ff.mode;
endmodule // caf_filter
`default_nettype wire

// file: pkg/caf_consts.svh
`ifndef CAF_CONSTS_SVH
`define CAF_CONSTS_SVH
// Register index space: masks at indices 0..3, filters at 16..31, control at 32..34
`define CAF_ADDR_W 8
`define CAF_MASK_BASE 8'h00
`define CAF_FILT_BASE 8'h40
`define CAF_ENABLE_ADDR 8'h80
`define CAF_MODE_ADDR 8'h84
`define CAF_STATUS_ADDR 8'h88
// Mask-select words, one per filter, first and last word
`define CAF_SEL_BASE 8'h90
`define CAF_SEL_LAST 8'hCC
// Field positions inside mask and filter words
`define CAF_SID_HI 31
`define CAF_SID_LO 21
`define CAF_TYPE_BIT 19
`define CAF_EID_HI 17
`define CAF_EID_LO 0
// Implemented bits of mask and filter words: 31..21, 19, 17..0
`define CAF_WORD_MASK 32'hFFEB_FFFF
`define CAF_MASK_RST 32'h0000_0000
`define CAF_FILT_RST 32'h0000_0000
// Operating mode value that opens the masks for writing
`define CAF_MODE_CONFIG 3'h4
`define CAF_MODE_RST 3'h4
`endif

// file: pkg/caf_pkg.sv
package caf_pkg;
	// Pipeline phase of the matcher
	typedef enum logic [1:0] {
		CAF_IDLE,
		CAF_SCAN,
		CAF_DONE
	} caf_phase_t;
endpackage

// file: logic/caf_word_mem.sv
`timescale 1ns/1ps
`default_nettype none
// Small register-file memory, registered read port, per-word write
module caf_word_mem #(
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [31:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [31:0] rd_data
);
	// Storage; reset clears all words so reads are never unknown
	logic [31:0] mem_ff [DEPTH];
	// Write and registered read
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_ff[i] <= 32'h0000_0000;
			end
			rd_data <= 32'h0000_0000;
		end else begin
			if (wr_en) begin
				mem_ff[wr_addr] <= wr_data;
			end
			rd_data <= mem_ff[rd_addr];
		end
	end
endmodule // caf_word_mem
`default_nettype wire

// file: tb/caf_rx_src.sv
`timescale 1ns/1ps
`default_nettype none
// Protocol-engine stand-in: offers queued identifiers, one per scan slot
module caf_rx_src (
	input wire logic core_clk,
	input wire logic arst_n,
	output logic rx_valid,
	output logic [10:0] rx_std_id,
	output logic [17:0] rx_ext_id,
	output logic rx_is_ext
);
	logic [29:0] q[$]; // Pending {type, std, ext}
	logic [4:0] cnt_ff; // Cycles left in the current scan
	// Next offer lands in the result cycle, never earlier; idle lines toggle
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_valid <= 1'b0;
			cnt_ff <= 5'h00;
			{rx_is_ext, rx_std_id, rx_ext_id} <= 30'h0;
		end else if (q.size() > 0 && cnt_ff <= 5'h01) begin
			{rx_is_ext, rx_std_id, rx_ext_id} <= q.pop_front();
			rx_valid <= 1'b1;
			cnt_ff <= 5'h13;
		end else begin
			rx_valid <= 1'b0;
			{rx_is_ext, rx_std_id, rx_ext_id} <= ~{rx_is_ext, rx_std_id, rx_ext_id};
			if (cnt_ff != 5'h00) cnt_ff <= cnt_ff - 5'h01;
		end
	end
endmodule // caf_rx_src
`default_nettype wire

// file: tb/caf_filter_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "caf_consts.svh"
// Watches bus answers, mode updates and match timing at the ports
module caf_chk #(
	parameter int NUM_FILT = 16,
	parameter int NUM_MASK = 4
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic rx_valid,
	input wire logic match_valid,
	input wire logic match_hit,
	input wire logic [3:0] match_index,
	input wire logic [2:0] operating_mode_field
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// Scan length holds only while no filter word is read mid-scan
	sequence s_quiet; ##1 (!match_valid) [*8]; endsequence
	property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data off cycle");
	property p_rsv; $past(reg_rd) && !$past(reg_addr[7]) |-> !reg_rdata[20] && !reg_rdata[18];
	endproperty
	a_rsv: assert property (p_rsv) else $error("unused bit read as one");
	property p_lat; match_valid |-> $past(rx_valid, 19); endproperty
	a_lat: assert property (p_lat) else $error("result at wrong time");
	property p_pulse; match_valid |=> !match_valid; endproperty
	a_pulse: assert property (p_pulse) else $error("result pulse too long");
	property p_hold; !match_valid |-> $stable(match_hit) && $stable(match_index); endproperty
	a_hold: assert property (p_hold) else $error("result moved between scans");
	property p_mode_keep;
		!($past(reg_wr) && $past(reg_addr) == `CAF_MODE_ADDR) |-> $stable(operating_mode_field);
	endproperty
	a_mode_keep: assert property (p_mode_keep) else $error("mode moved unasked");
	property p_mode_wr;
		$past(reg_wr) && $past(reg_addr) == `CAF_MODE_ADDR |->
			operating_mode_field == $past(reg_wdata[2:0]);
	endproperty
	a_mode_wr: assert property (p_mode_wr) else $error("mode write lost");
	property p_b2b; rx_valid && match_valid |-> s_quiet ##11 match_valid; endproperty
	a_b2b: assert property (p_b2b) else $error("back to back scan mistimed");
endmodule // caf_chk
bind caf_filter caf_chk #(.NUM_FILT(NUM_FILT), .NUM_MASK(NUM_MASK)) i_chk (
	.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
	.match_valid(match_valid), .match_hit(match_hit), .match_index(match_index),
	.operating_mode_field(operating_mode_field));
`default_nettype wire

// file: tb/test_can_acceptance_filter.sv
`timescale 1ns/1ps
`default_nettype none
`include "caf_consts.svh"
module test_can_acceptance_filter;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic rx_valid, rx_is_ext, match_valid, match_hit;
	logic [10:0] rx_std_id;
	logic [17:0] rx_ext_id;
	logic [3:0] match_index;
	logic [2:0] operating_mode_field;
	logic [4:0] res[$]; // Collected {hit, index}
	int bad_count = 0;
	int samples_checked = 0;
	caf_filter i_dut (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.rx_valid(rx_valid), .rx_std_id(rx_std_id), .rx_ext_id(rx_ext_id),
		.rx_is_ext(rx_is_ext), .match_valid(match_valid), .match_hit(match_hit),
		.match_index(match_index), .operating_mode_field(operating_mode_field));
	caf_rx_src i_src (.core_clk(core_clk), .arst_n(arst_n), .rx_valid(rx_valid),
		.rx_std_id(rx_std_id), .rx_ext_id(rx_ext_id), .rx_is_ext(rx_is_ext));
	initial forever #4 core_clk = ~core_clk;
	// Results are taken in their single valid cycle
	always @(posedge core_clk) if (match_valid === 1'b1) res.push_back({match_hit, match_index});
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// A gap cycle after each write keeps the strobe to one assignment per step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, exp);
		@(posedge core_clk);
	endtask
	// Queue identifiers, wait for all results, compare; misses judge hit only
	task automatic run(input logic [29:0] ids[$], input logic [4:0] exp[$]);
		foreach (ids[i]) i_src.q.push_back(ids[i]);
		repeat (400) if (res.size() < ids.size()) @(posedge core_clk);
		check(32'(res.size()), 32'(ids.size()));
		foreach (exp[i]) check({27'h0, res.pop_front() & (exp[i][4] ? 5'h1F : 5'h10)}, exp[i]);
	endtask
	task automatic t_regs();
		rchk(`CAF_MASK_BASE, `CAF_MASK_RST);
		rchk(`CAF_MODE_ADDR, 32'h4);
		rchk(8'hFC, 32'h0);
		wr(8'h0C, 32'hFFFF_FFFF);
		rchk(8'h0C, `CAF_WORD_MASK);
		wr(8'h7C, 32'hFFFF_FFFF);
		rchk(8'h7C, `CAF_WORD_MASK);
	endtask
	task automatic t_lock();
		wr(`CAF_ENABLE_ADDR, 32'h8000);
		wr(8'h7C, 32'h0);
		rchk(8'h7C, `CAF_WORD_MASK);
		wr(`CAF_MODE_ADDR, 32'h0);
		wr(8'h0C, 32'h0);
		rchk(8'h0C, `CAF_WORD_MASK);
		wr(`CAF_MODE_ADDR, 32'h4);
		wr(8'h0C, 32'h0);
		rchk(8'h0C, 32'h0);
		wr(`CAF_ENABLE_ADDR, 32'h0);
		wr(8'h7C, 32'h0);
		rchk(8'h7C, 32'h0);
	endtask
	task automatic t_match();
		wr(8'h00, 32'hFFE8_0000);
		wr(8'h04, 32'hFFEB_FFFF);
		wr(8'h4C, 32'h2460_0000);
		wr(8'h54, 32'h2468_0000);
		wr(8'h5C, 32'h0AAA_AAAA);
		wr(8'hAC, 32'h1);
		wr(`CAF_ENABLE_ADDR, 32'hA8);
		run('{{1'b0, 11'h123, 18'h0}, {1'b1, 11'h123, 18'h15}, {1'b0, 11'h124, 18'h0},
			{1'b1, 11'h055, 18'h2AAAA}, {1'b1, 11'h055, 18'h2AAAB},
			{1'b0, 11'h055, 18'h2AAAA}}, '{5'h13, 5'h15, 5'h0, 5'h17, 5'h0, 5'h0});
		wr(8'h00, 32'hFFE0_0000);
		run('{{1'b1, 11'h123, 18'h0}}, '{5'h13});
		rchk(`CAF_STATUS_ADDR, 32'h0028_0013);
	endtask
	task automatic close_out();
		$display("Checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		#200000;
		bad_count++;
		close_out();
	end
	initial begin
		repeat (16) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		t_regs();
		t_lock();
		t_match();
		close_out();
	end
endmodule // test_can_acceptance_filter
`default_nettype wire
